// >>> src/pend_flag.sv
// one sticky flag, hardware set wins over software write
module pend_flag (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic ce_in,
	input wire logic set_in,
	input wire logic wr_in,
	input wire logic wdata_in,
	output logic q_out
);
	wire next_q = set_in | (wr_in ? wdata_in : q_out);
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			q_out <= 1'b0;
		end else if (ce_in) begin
			q_out <= next_q;
		end
	end
endmodule

// >>> src/rank_encoder.sv
// fixed rank encoder, highest set bit wins
module rank_encoder #(
	parameter int N = 16,
	parameter int IW = $clog2(N)
) (
	input wire logic [N-1:0] active_in,
	output logic [IW-1:0] index_out
);
	always_comb begin
		index_out = '0;
		for (int i = 0; i < N; i++) begin
			if (active_in[i]) begin
				index_out = IW'(i);
			end
		end
	end
endmodule

// >>> src/vectored_interrupt_arbiter.sv
// top of the vectored interrupt arbiter
`include "via_cfg.svh"
module vectored_interrupt_arbiter #(
	parameter int ACK_CYCLES = `VIA_ACK_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic ce_in,
	input wire via_pkg::reg_req_t reg_req_in,
	output logic [7:0] reg_rdata_out,
	input wire logic [13:0] src_event_in,
	input wire via_pkg::core_evt_t core_evt_in,
	input wire logic icycle_in,
	input wire logic [14:0] next_pc_in,
	input wire logic [14:0] vis_pc_in,
	output logic mem_rd_out,
	output logic [14:0] mem_addr_out,
	input wire logic [7:0] mem_data_in,
	output logic push_out,
	output logic [14:0] push_data_out,
	output logic pop_out,
	input wire logic [14:0] stack_data_in,
	output via_pkg::pc_load_t pc_load_out,
	output logic global_int_enable_out,
	output logic int_req_out,
	output logic busy_out
);
	import via_pkg::*;

	localparam logic [2:0] ACK_LAST = 3'(ACK_CYCLES - 1);

	seq_state_t state;
	seq_state_t next_state;
	logic [13:0] enable_mask;
	logic [13:0] pend;
	logic trap_pending_flag;
	logic trap_due;
	logic [2:0] ack_cnt;
	logic [7:0] vis_code;
	logic [6:0] vis_block;
	logic [7:0] vec_hi;
	logic [3:0] rank_idx;

	// register decode
	wire wr_psw = reg_req_in.wr && reg_req_in.addr == `VIA_REG_PSW;
	wire wr_en_lo = reg_req_in.wr && reg_req_in.addr == `VIA_REG_EN_LO;
	wire wr_en_hi = reg_req_in.wr && reg_req_in.addr == `VIA_REG_EN_HI;
	wire wr_pnd_lo = reg_req_in.wr && reg_req_in.addr == `VIA_REG_PND_LO;
	wire wr_pnd_hi = reg_req_in.wr && reg_req_in.addr == `VIA_REG_PND_HI;

	// pending flags, one per maskable source
	genvar gi;
	generate
		for (gi = 0; gi < `VIA_NSRC; gi++) begin : g_pend
			pend_flag u_flag (
				.clk_in(clk_in),
				.rst_b_in(rst_b_in),
				.ce_in(ce_in),
				.set_in(src_event_in[gi]),
				.wr_in(gi < 8 ? wr_pnd_lo : wr_pnd_hi),
				.wdata_in(reg_req_in.wdata[gi % 8]),
				.q_out(pend[gi])
			);
		end
	endgenerate

	// trap pending flag, read-only on the register map as status bit 0
	pend_flag u_trap_flag (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.ce_in(ce_in),
		.set_in(core_evt_in.trap),
		.wr_in(core_evt_in.clr_trap),
		.wdata_in(1'b0),
		.q_out(trap_pending_flag)
	);

	// qualification
	wire [13:0] active = enable_mask & pend;
	wire maskable_req = global_int_enable_out && !trap_pending_flag &&
		(|active);
	wire idle = state == ST_IDLE;
	wire at_boundary = idle && core_evt_in.instr_start &&
		!core_evt_in.skip;
	wire take_ack = at_boundary && (trap_due || maskable_req);
	wire take_vis = idle && core_evt_in.vector_select_instr && !take_ack;
	wire take_return_from_int_instr = idle && core_evt_in.return_from_int_instr && !take_ack && !take_vis;
	wire ack_done = state == ST_ACK && icycle_in && ack_cnt == ACK_LAST;

	// arbitration: trap on top, default always present at the bottom
	wire [15:0] rank_vec = {trap_pending_flag, active, 1'b1};
	rank_encoder #(
		.N(`VIA_NSLOT)
	) u_rank (
		.active_in(rank_vec),
		.index_out(rank_idx)
	);
	wire [7:0] arb_code = `VIA_CODE_BASE +
		{3'b000, rank_idx, 1'b0};
	wire [6:0] next_block = (vis_pc_in[7:0] == `VIA_LAST_BYTE) ?
		7'(vis_pc_in[14:8] + 7'h01) : vis_pc_in[14:8];

	// next values
	wire next_gie = take_ack ? 1'b0 :
		take_return_from_int_instr ? 1'b1 :
		wr_psw ? reg_req_in.wdata[`VIA_GIE_BIT] :
		global_int_enable_out;
	wire next_trap_due = core_evt_in.trap | (take_ack ? 1'b0 : trap_due);
	wire [14:0] vec_addr = {vec_hi[6:0], mem_data_in};
	wire next_load = ack_done || state == ST_VEND || state == ST_PWAIT;
	wire [14:0] next_pc_addr = ack_done ? `VIA_ENTRY :
		(state == ST_VEND) ? vec_addr : stack_data_in;
	wire next_mem_rd = take_vis || state == ST_VHI;
	wire [14:0] next_mem_addr = take_vis ? {next_block, arb_code} :
		{vis_block, vis_code | 8'h01};
	wire next_push = state == ST_ACK && icycle_in && ack_cnt == 3'h0;
	wire [7:0] status_byte = {4'h0, maskable_req, ~idle, trap_due,
		trap_pending_flag};
	wire [7:0] rd_mux = (reg_req_in.addr == `VIA_REG_PSW) ?
		{7'h00, global_int_enable_out} :
		(reg_req_in.addr == `VIA_REG_EN_LO) ? enable_mask[7:0] :
		(reg_req_in.addr == `VIA_REG_EN_HI) ? {2'b00, enable_mask[13:8]} :
		(reg_req_in.addr == `VIA_REG_PND_LO) ? pend[7:0] :
		(reg_req_in.addr == `VIA_REG_PND_HI) ? {2'b00, pend[13:8]} :
		(reg_req_in.addr == `VIA_REG_STATUS) ? status_byte :
		(reg_req_in.addr == `VIA_REG_CODE) ? vis_code : 8'h00;

	// sequencer
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (take_ack) begin
					next_state = ST_ACK;
				end else if (take_vis) begin
					next_state = ST_VHI;
				end else if (take_return_from_int_instr) begin
					next_state = ST_POP;
				end
			end
			ST_ACK: begin
				if (ack_done) begin
					next_state = ST_IDLE;
				end
			end
			ST_VHI: next_state = ST_VLO;
			ST_VLO: next_state = ST_VEND;
			ST_VEND: next_state = ST_IDLE;
			ST_POP: next_state = ST_PWAIT;
			ST_PWAIT: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			state <= ST_IDLE;
		end else if (ce_in) begin
			state <= next_state;
		end
	end

	// global enable and enables
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			global_int_enable_out <= 1'b0;
			enable_mask <= 14'h0000;
		end else if (ce_in) begin
			global_int_enable_out <= next_gie;
			if (wr_en_lo) begin
				enable_mask[7:0] <= reg_req_in.wdata;
			end
			if (wr_en_hi) begin
				enable_mask[13:8] <= reg_req_in.wdata[5:0];
			end
		end
	end

	// trap acknowledge owed, cycle counter
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			trap_due <= 1'b0;
			ack_cnt <= 3'h0;
		end else if (ce_in) begin
			trap_due <= next_trap_due;
			if (take_ack) begin
				ack_cnt <= 3'h0;
			end else if (state == ST_ACK && icycle_in) begin
				ack_cnt <= ack_cnt + 3'h1;
			end
		end
	end

	// vector select capture
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			vis_code <= `VIA_RST_BYTE;
			vis_block <= 7'h00;
			vec_hi <= `VIA_RST_BYTE;
		end else if (ce_in) begin
			if (take_vis) begin
				vis_code <= arb_code;
				vis_block <= next_block;
			end
			if (state == ST_VLO) begin
				vec_hi <= mem_data_in;
			end
		end
	end

	// program memory, stack and pc outputs
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			mem_rd_out <= 1'b0;
			mem_addr_out <= 15'h0000;
			push_out <= 1'b0;
			push_data_out <= 15'h0000;
			pop_out <= 1'b0;
			pc_load_out <= '0;
		end else if (ce_in) begin
			mem_rd_out <= next_mem_rd;
			mem_addr_out <= next_mem_addr;
			push_out <= next_push;
			if (take_ack) begin
				push_data_out <= next_pc_in;
			end
			pop_out <= take_return_from_int_instr;
			pc_load_out.valid <= next_load;
			pc_load_out.addr <= next_pc_addr;
		end
	end

	// register read and status outputs
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			reg_rdata_out <= `VIA_RST_BYTE;
			int_req_out <= 1'b0;
			busy_out <= 1'b0;
		end else if (ce_in) begin
			reg_rdata_out <= reg_req_in.rd ? rd_mux : 8'h00;
			int_req_out <= maskable_req || trap_due;
			busy_out <= next_state != ST_IDLE;
		end
	end

	// checks
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);

	a_reset_clear: assert property (
		$rose(rst_b_in) |-> !global_int_enable_out && enable_mask == 14'h0000 &&
			pend == 14'h0000 && !trap_pending_flag)
	else $error("state not cleared by reset");

	a_pend_sets: assert property (
		ce_in && src_event_in != 14'h0000 |=>
			(pend & $past(src_event_in)) == $past(src_event_in))
	else $error("event lost on a source");

	a_req_taken: assert property (
		ce_in && at_boundary && maskable_req |=> state == ST_ACK)
	else $error("qualified request not acknowledged");

	a_nmi_blocks: assert property (
		ce_in && at_boundary && trap_pending_flag && !trap_due |=>
			state != ST_ACK)
	else $error("maskable taken while trap in service");

	a_skip_waits: assert property (
		ce_in && idle && core_evt_in.skip |=> state != ST_ACK)
	else $error("acknowledge on a skipped instruction");

	a_ack_gie: assert property (
		ce_in && take_ack |=> !global_int_enable_out &&
			push_data_out == $past(next_pc_in))
	else $error("acknowledge entry wrong");

	a_ack_length: assert property (
		ce_in && ack_done |=> state == ST_IDLE && pc_load_out.valid &&
			pc_load_out.addr == `VIA_ENTRY && $past(ack_cnt) == 3'h6)
	else $error("acknowledge length or entry wrong");

	a_ack_keeps_pend: assert property (
		ce_in && take_ack && !wr_pnd_lo && !wr_pnd_hi |=>
			(pend & $past(pend)) == $past(pend))
	else $error("acknowledge cleared a pending flag");

	a_ack_push: assert property (
		ce_in && take_ack |=> ##[0:8] push_out)
	else $error("return address not pushed");

	a_gie_write: assert property (
		ce_in && wr_psw && !take_ack && !take_return_from_int_instr |=>
			global_int_enable_out == $past(reg_req_in.wdata[`VIA_GIE_BIT]))
	else $error("global enable write lost");

	a_trap_top: assert property (
		ce_in && take_vis && trap_pending_flag |=>
			vis_code == `VIA_CODE_TRAP)
	else $error("trap not ranked highest");

	a_rank_order: assert property (
		ce_in && take_vis && !trap_pending_flag && active != 14'h0000 |=>
			($past(active) >> (vis_code[4:1] - 4'h1)) == 14'h0001)
	else $error("top maskable not chosen");

	a_vis_default: assert property (
		ce_in && take_vis && !trap_pending_flag && active == 14'h0000 |=>
			vis_code == `VIA_CODE_BASE)
	else $error("default vector not used");

	a_vis_block: assert property (
		ce_in && take_vis && vis_pc_in[7:0] == `VIA_LAST_BYTE |=>
			mem_addr_out[14:8] == 7'($past(vis_pc_in[14:8]) + 7'h01))
	else $error("table block wrong for last byte");

	a_vis_bytes: assert property (
		ce_in && take_vis |=> mem_rd_out && !mem_addr_out[0] ##1
			mem_rd_out && mem_addr_out[0])
	else $error("vector bytes out of order");

	a_return_from_int_instr_pop: assert property (
		ce_in && take_return_from_int_instr |=> global_int_enable_out && pop_out)
	else $error("return did not restore enable");

	a_return_from_int_instr_load: assert property (
		ce_in && state == ST_PWAIT |=> pc_load_out.valid &&
			pc_load_out.addr == $past(stack_data_in))
	else $error("return address not loaded");

	a_trap_sets: assert property (
		ce_in && core_evt_in.trap |=> trap_pending_flag && trap_due)
	else $error("trap not recorded");

	a_trap_clear: assert property (
		ce_in && core_evt_in.clr_trap && !core_evt_in.trap |=>
			!trap_pending_flag)
	else $error("trap flag not cleared");

	c_ack: cover property (ce_in && ack_done);
	c_vis: cover property (ce_in && state == ST_VEND);
	c_return_from_int_instr: cover property (ce_in && state == ST_PWAIT);
	c_default: cover property (ce_in && take_vis && !trap_pending_flag &&
		active == 14'h0000);
	c_nest: cover property (state == ST_IDLE && global_int_enable_out &&
		take_ack && !trap_due);
endmodule

// >>> src/via_cfg.svh
// constants of the vectored interrupt arbiter
// How it works
// - maskable request needs pending, enable, global enable, no trap in service
// - source event sets its pending flag even while disabled
// - reset clears pending flags, enables and the global enable
// - enabling an already pending source requests at once
// - simultaneous qualifiers: highest rank serviced, others stay pending
// - acknowledge only at a normal instruction start, after any skip
// - acknowledge clears global enable, pushes next address, loads 00ff
// - acknowledge sequence lasts seven instruction cycles
// - trap is non-maskable and highest, default vector is lowest
// - writing global enable during maskable service re-enables nesting
// - return sets global enable, pops address, loads it into pc
// - still pending qualifiers are serviced right after return
// - vector select picks highest enabled pending source, jumps through table
// - table at top of the vector select block, next block if last byte
// - vector is 15 bits in two bytes, high byte at lower address
// - lowest rank at e0/e1, two bytes per rank, trap at fe/ff
// - nothing active, no trap pending: vector select uses the default vector
// - a source is active when enable and pending are both set
// - fourteen maskable inputs, each with fixed rank and slot
// - arbitration in first vector select cycle gives even code e0..fe
// - trap pending flag set by trap, cleared by reset and clear instruction
`ifndef VIA_CFG_SVH
`define VIA_CFG_SVH
`define VIA_NSRC 14
`define VIA_NSLOT 16
`define VIA_ENTRY 15'h00ff
`define VIA_ACK_CYCLES 7
`define VIA_CODE_BASE 8'he0
`define VIA_CODE_TRAP 8'hfe
`define VIA_CODE_TOP 8'hfc
`define VIA_LAST_BYTE 8'hff
`define VIA_REG_PSW 3'h0
`define VIA_REG_EN_LO 3'h1
`define VIA_REG_EN_HI 3'h2
`define VIA_REG_PND_LO 3'h3
`define VIA_REG_PND_HI 3'h4
`define VIA_REG_STATUS 3'h5
`define VIA_REG_CODE 3'h6
`define VIA_GIE_BIT 0
`define VIA_RST_BYTE 8'h00
`endif

// >>> src/via_pkg.sv
// types of the vectored interrupt arbiter
package via_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ACK = 3'b001,
		ST_VHI = 3'b010,
		ST_VLO = 3'b011,
		ST_VEND = 3'b100,
		ST_POP = 3'b101,
		ST_PWAIT = 3'b110
	} seq_state_t;
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
	typedef struct packed {
		logic instr_start;
		logic skip;
		logic trap;
		logic clr_trap;
		logic return_from_int_instr;
		logic vector_select_instr;
	} core_evt_t;
	typedef struct packed {
		logic valid;
		logic [14:0] addr;
	} pc_load_t;
endpackage

// >>> tb/core_model.sv
// core model: instruction cycle pulses, program memory and return stack
module core_model (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic mem_rd_in,
	input wire logic [14:0] mem_addr_in,
	input wire logic push_in,
	input wire logic [14:0] push_data_in,
	input wire logic pop_in,
	output logic icycle_out,
	output logic [7:0] mem_data_out,
	output logic [14:0] stack_data_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] div;
	logic [14:0] stk[$];
	initial begin
		div = 2'h0;
		icycle_out = 1'b0;
		mem_data_out = 8'h00;
		stack_data_out = 15'h0000;
	end
	// released lines show the inverse of the last value
	always @(posedge clk_in) begin
		div <= rst_b_in ? div + 2'h1 : 2'h0;
		icycle_out <= (div == 2'h2);
		mem_data_out <= mem_rd_in ? mem_addr_in[7:0] ^ 8'h3c : ~mem_data_out;
		if (push_in) begin
			stk.push_back(push_data_in);
		end
		if (pop_in && stk.size() > 0) begin
			stack_data_out <= stk.pop_back();
		end else begin
			stack_data_out <= ~stack_data_out;
		end
	end
endmodule

// >>> tb/vectored_interrupt_arbiter_tb.sv
// self-checking bench of the vectored interrupt arbiter
`include "via_cfg.svh"
module vectored_interrupt_arbiter_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import via_pkg::*;
	localparam logic [5:0] e_start = 6'b100000;
	localparam logic [5:0] e_skip = 6'b110000;
	localparam logic [5:0] e_trap = 6'b001000;
	localparam logic [5:0] e_clrt = 6'b000100;
	localparam logic [5:0] e_ret = 6'b000010;
	localparam logic [5:0] e_vsel = 6'b000001;
	logic clk_in, rst_b_in, icycle, mem_rd, push, pop, global_int_enable, int_req, busy;
	logic ce;
	reg_req_t req;
	core_evt_t cev;
	logic [13:0] src;
	logic [14:0] next_pc, vis_pc, mem_addr, push_data, stack_data, a, ma;
	logic [7:0] rdata, mem_data;
	pc_load_t pc_load;
	int failures, checks_done, cycles, n;
	vectored_interrupt_arbiter vectored_interrupt_arbiter_i (
		.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce),
		.reg_req_in(req), .reg_rdata_out(rdata), .src_event_in(src),
		.core_evt_in(cev), .icycle_in(icycle), .next_pc_in(next_pc),
		.vis_pc_in(vis_pc), .mem_rd_out(mem_rd), .mem_addr_out(mem_addr),
		.mem_data_in(mem_data), .push_out(push), .push_data_out(push_data),
		.pop_out(pop), .stack_data_in(stack_data), .pc_load_out(pc_load),
		.global_int_enable_out(global_int_enable), .int_req_out(int_req), .busy_out(busy)
	);
	core_model core_model_i (
		.clk_in(clk_in), .rst_b_in(rst_b_in), .mem_rd_in(mem_rd),
		.mem_addr_in(mem_addr), .push_in(push), .push_data_in(push_data),
		.pop_in(pop), .icycle_out(icycle), .mem_data_out(mem_data),
		.stack_data_out(stack_data)
	);
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	task end_of_test;
		if (failures == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			end_of_test;
		end
	end
	task check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t ns: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [2:0] ad, input logic [7:0] d);
		@(posedge clk_in);
		req <= '{ad, d, 1'b1, 1'b0};
		@(posedge clk_in);
		req <= '0;
	endtask
	task rd(input logic [2:0] ad, input logic [7:0] exp);
		@(posedge clk_in);
		req <= '{ad, 8'h00, 1'b0, 1'b1};
		@(posedge clk_in);
		req <= '0;
		#1 check({8'h00, rdata}, {8'h00, exp});
	endtask
	task evt(input logic [5:0] e);
		@(posedge clk_in);
		cev <= e;
		@(posedge clk_in);
		cev <= '0;
		#1;
	endtask
	task fire(input int i);
		@(posedge clk_in);
		src <= 14'h0001 << i;
		@(posedge clk_in);
		src <= '0;
	endtask
	task settle;
		repeat (2) @(posedge clk_in);
		#1;
	endtask
	task wait_load;
		a = '1;
		n = 0;
		ma = '1;
		for (int k = 0; k < 300; k++) begin
			if (pc_load.valid === 1'b1) begin
				a = pc_load.addr;
				break;
			end
			if (busy === 1'b1 && icycle === 1'b1) n++;
			if (mem_rd === 1'b1 && ma === '1) ma = mem_addr;
			@(posedge clk_in);
			#1;
		end
	endtask
	task vsel(input logic [14:0] pc, input logic [7:0] code);
		logic [6:0] blk;
		logic [7:0] hi, lo;
		blk = pc[14:8] + {6'h00, pc[7:0] == 8'hff};
		hi = code ^ 8'h3c;
		lo = (code | 8'h01) ^ 8'h3c;
		@(posedge clk_in);
		vis_pc <= pc;
		evt(e_vsel);
		wait_load;
		check({1'b0, ma}, {1'b0, blk, code});
		check({1'b0, a}, {1'b0, hi[6:0], lo});
		rd(`VIA_REG_CODE, code);
	endtask
	task s_reset;
		for (int i = 0; i < 8; i++) if (i != 6) rd(i[2:0], 8'h00);
	endtask
	task s_mask;
		fire(3);
		rd(`VIA_REG_PND_LO, 8'h08);
		wr(`VIA_REG_PSW, 8'h01);
		settle;
		check({15'h0, int_req}, 16'h0000);
		wr(`VIA_REG_EN_LO, 8'h08);
		settle;
		check({15'h0, int_req}, 16'h0001);
		@(posedge clk_in);
		ce <= 1'b0;
		src <= 14'h0020;
		@(posedge clk_in);
		ce <= 1'b1;
		src <= '0;
		rd(`VIA_REG_PND_LO, 8'h08);
	endtask
	task s_ack;
		evt(e_skip);
		check({15'h0, busy}, 16'h0000);
		evt(e_start);
		check({15'h0, global_int_enable}, 16'h0000);
		wait_load;
		check({1'b0, a}, {1'b0, `VIA_ENTRY});
		check(n[15:0], 16'h0007);
		check({1'b0, push_data}, {1'b0, next_pc});
		rd(`VIA_REG_PND_LO, 8'h08);
	endtask
	task s_vis;
		fire(10);
		wr(`VIA_REG_EN_HI, 8'h04);
		vsel(15'h00ff, 8'hf6);
		vsel(15'h0234, 8'hf6);
		wr(`VIA_REG_PND_HI, 8'h00);
		vsel(15'h0100, 8'he8);
		wr(`VIA_REG_PND_LO, 8'h00);
		vsel(15'h01ff, 8'he0);
	endtask
	task s_ret;
		evt(e_ret);
		check({15'h0, global_int_enable}, 16'h0001);
		wait_load;
		check({1'b0, a}, 16'h1234);
	endtask
	task s_trap;
		wr(`VIA_REG_PSW, 8'h00);
		evt(e_trap);
		rd(`VIA_REG_STATUS, 8'h03);
		evt(e_start);
		wait_load;
		check({1'b0, a}, {1'b0, `VIA_ENTRY});
		fire(3);
		wr(`VIA_REG_PSW, 8'h01);
		settle;
		check({15'h0, int_req}, 16'h0000);
		evt(e_start);
		check({15'h0, busy}, 16'h0000);
		vsel(15'h0300, 8'hfe);
		evt(e_clrt);
		rd(`VIA_REG_STATUS, 8'h08);
		check({15'h0, int_req}, 16'h0001);
	endtask
	initial begin
		req = '0;
		ce = 1'b1;
		cev = '0;
		src = '0;
		next_pc = 15'h1234;
		vis_pc = 15'h00ff;
		failures = 0;
		checks_done = 0;
		cycles = 0;
		rst_b_in = 1'b0;
		repeat (4) @(posedge clk_in);
		rst_b_in <= 1'b1;
		s_reset;
		s_mask;
		s_ack;
		s_vis;
		s_ret;
		s_trap;
		end_of_test;
	end
endmodule
